// ==== vfp_pkg.sv ====
package vfp_pkg;
   // word layout: sign, biased exponent, fraction with binary point above bit 47
   localparam int WORD_W = 64;
   localparam int COEF_W = 48;
   localparam int EXP_W = 15;
   localparam int SIGN_BIT = 63;
   localparam int EXP_LSB = 48;
   localparam logic [14:0] EXP_BIAS = 15'h4000;
   localparam int HALF_ZERO_BITS = 18;
   localparam int HALF_ACC_BITS = 30;
   localparam int MAX_ELEMS = 64;
   localparam int VL_W = 7;
   localparam int VREG_W = 3;
   localparam int OP_W = 7;
   localparam int RF_LATENCY = 1;
   localparam int PIPE_LATENCY = 3;
   localparam logic [63:0] FP_TWO = 64'h4002_8000_0000_0000;
   localparam logic [48:0] RCP_SEED = 49'h1_8000_0000_0000;
   localparam logic [OP_W-1:0] OP_MUL_SV = 7'h70;
   localparam logic [OP_W-1:0] OP_MUL_VV = 7'h71;
   localparam logic [OP_W-1:0] OP_HMUL_SV = 7'h72;
   localparam logic [OP_W-1:0] OP_HMUL_VV = 7'h73;
   localparam logic [OP_W-1:0] OP_RMUL_SV = 7'h74;
   localparam logic [OP_W-1:0] OP_RMUL_VV = 7'h75;
   localparam logic [OP_W-1:0] OP_IMUL_SV = 7'h76;
   localparam logic [OP_W-1:0] OP_IMUL_VV = 7'h77;
   localparam logic [OP_W-1:0] OP_ADD_SV = 7'h78;
   localparam logic [OP_W-1:0] OP_ADD_VV = 7'h79;
   localparam logic [OP_W-1:0] OP_SUB_SV = 7'h7a;
   localparam logic [OP_W-1:0] OP_SUB_VV = 7'h7b;
   localparam logic [OP_W-1:0] OP_RECIP = 7'h7c;

   typedef enum logic [1:0] {MUL_PLAIN, MUL_HALF, MUL_ROUND, MUL_TWO} mul_mode_t;
   typedef enum logic [2:0] {UNIT_NONE = 3'h0, UNIT_MUL = 3'h1, UNIT_ADD = 3'h2, UNIT_RCP = 3'h4} unit_t;

   typedef struct packed {
      logic [OP_W-1:0] op;
      logic [VREG_W-1:0] dst;
      logic [VREG_W-1:0] src_j;
      logic [VREG_W-1:0] src_k;
      logic [WORD_W-1:0] scalar;
   } cmd_t;

   typedef struct packed {
      logic en;
      logic [VREG_W-1:0] vreg;
      logic [VL_W-2:0] idx;
      logic [WORD_W-1:0] data;
   } wr_t;
endpackage

// ==== vector_float_mul_add_recip.sv ====
// What this block does
// - scalar times vector multiply writes each product to matching destination element
// - vector times vector multiply multiplies corresponding elements pairwise
// - plain, half and rounded multiplies leave product unnormalized when either operand is unnormalized
// - half-precision multiply rounds then clears the low 18 result bits
// - rounded multiply variants give full-precision rounded products
// - reciprocal-iteration multiply variants output two minus the product
// - each operation processes exactly vector-length elements, clipped to ELEMS, from element zero
// - all eight multiply opcodes run in the multiply pipeline
// - scalar plus vector add adds scalar to every vector element
// - every add and subtract result leaves normalized
// - scalar selector zero on add just normalizes each vector element
// - vector plus vector add writes normalized pairwise sums
// - scalar minus vector subtracts; selector zero gives normalized negation
// - vector minus vector writes normalized first minus second source
// - the four add and subtract opcodes run in the add pipeline
// - reciprocal gives approximate reciprocal; zero or unnormalized input undefined
// - reciprocal runs in its own pipeline apart from multiply and add
// - half-precision product is good enough for a 30-bit division sequence
// - destination elements at or beyond vector length stay unwritten
`timescale 1ns/1ps
module vector_float_mul_add_recip
#(
   parameter int ELEMS = vfp_pkg::MAX_ELEMS
)
(
   // clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // instruction issue
   input wire logic issue_valid_in,
   input wire vfp_pkg::cmd_t issue_cmd_in,
   input wire logic [vfp_pkg::VL_W-1:0] vector_length_register_in,
   output logic issue_ready_out,
   output logic done_out,
   // vector register file read port, data one cycle after the request
   output logic rd_en_out,
   output logic [vfp_pkg::VREG_W-1:0] rd_first_vector_source_out,
   output logic [vfp_pkg::VREG_W-1:0] rd_second_vector_source_out,
   output logic [vfp_pkg::VL_W-2:0] rd_idx_out,
   input wire logic [vfp_pkg::WORD_W-1:0] first_vector_source_in,
   input wire logic [vfp_pkg::WORD_W-1:0] second_vector_source_in,
   // destination vector write port
   output vfp_pkg::wr_t destination_vector_out
);
   import vfp_pkg::*;

   initial
   begin
      if (ELEMS < 1 || ELEMS > MAX_ELEMS)
         $error("ELEMS out of range");
   end

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} state_t;

   function automatic logic [63:0] fmul(input logic [63:0] a, input logic [63:0] b, input mul_mode_t m);
      logic [95:0] p;
      logic [16:0] e;
      logic [47:0] c;
      p = a[COEF_W-1:0] * b[COEF_W-1:0];
      e = {2'h0, a[62:EXP_LSB]} + {2'h0, b[62:EXP_LSB]} - {2'h0, EXP_BIAS};
      if (a[COEF_W-1] && b[COEF_W-1] && !p[95])
      begin
         p = p << 1;
         e = e - 17'h1;
      end
      c = p[95:COEF_W];
      if (m == MUL_HALF)
      begin
         c = c + (48'h1 << (HALF_ZERO_BITS - 1));
         c = c & ~((48'h1 << HALF_ZERO_BITS) - 48'h1);
      end
      else if (m != MUL_PLAIN)
         c = c + {47'h0, p[COEF_W-1]};
      return {a[SIGN_BIT] ^ b[SIGN_BIT], e[EXP_W-1:0], c};
   endfunction

   function automatic logic [63:0] fadd(input logic [63:0] a, input logic [63:0] b, input logic sub);
      logic sa;
      logic sb;
      logic [14:0] ea;
      logic [14:0] eb;
      logic [14:0] d;
      logic [48:0] ma;
      logic [48:0] mb;
      logic [48:0] s;
      logic [16:0] e;
      sa = a[SIGN_BIT];
      sb = b[SIGN_BIT] ^ sub;
      ea = a[62:EXP_LSB];
      eb = b[62:EXP_LSB];
      ma = {1'b0, a[COEF_W-1:0]};
      mb = {1'b0, b[COEF_W-1:0]};
      if (eb > ea)
      begin
         sa = sb;
         ea = eb;
         ma = mb;
         sb = a[SIGN_BIT];
         eb = a[62:EXP_LSB];
         mb = {1'b0, a[COEF_W-1:0]};
      end
      d = ea - eb;
      mb = (d > 15'd48) ? 49'h0 : mb >> d;
      if (sa == sb)
         s = ma + mb;
      else if (ma >= mb)
         s = ma - mb;
      else
      begin
         s = mb - ma;
         sa = sb;
      end
      e = {2'h0, ea};
      if (s[COEF_W])
      begin
         s = s >> 1;
         e = e + 17'h1;
      end
      for (int n = 0; n < COEF_W; n++)
      begin
         if (!s[COEF_W-1] && s != 49'h0)
         begin
            s = s << 1;
            e = e - 17'h1;
         end
      end
      if (s == 49'h0)
         return 64'h0;
      return {sa, e[EXP_W-1:0], s[COEF_W-1:0]};
   endfunction

   // linear seed, exact at the top of the fraction range, saturating to all ones at 0.5; caller refines it
   function automatic logic [63:0] frcp(input logic [63:0] a);
      logic [48:0] g;
      logic [15:0] e;
      g = RCP_SEED - {1'b0, a[COEF_W-1:0]};
      e = {EXP_BIAS, 1'b0} + 16'h1 - {1'b0, a[62:EXP_LSB]};
      if (g[COEF_W])
         g = {1'b0, {COEF_W{1'b1}}};
      return {a[SIGN_BIT], e[EXP_W-1:0], g[COEF_W-1:0]};
   endfunction

   function automatic unit_t unit_of(input logic [OP_W-1:0] op);
      if (op >= OP_MUL_SV && op <= OP_IMUL_VV)
         return UNIT_MUL;
      if (op >= OP_ADD_SV && op <= OP_SUB_VV)
         return UNIT_ADD;
      if (op == OP_RECIP)
         return UNIT_RCP;
      return UNIT_NONE;
   endfunction

   state_t state_reg;
   cmd_t cmd_reg;
   logic [VL_W-1:0] vl_reg;
   logic [VL_W-1:0] cnt_reg;
   logic rd_en_reg;
   logic [VL_W-2:0] rd_idx_reg;
   logic opv_reg;
   logic [VL_W-2:0] op_idx_reg;
   logic op_last_reg;
   logic rd_last_reg;
   unit_t res_unit_reg;
   logic [VL_W-2:0] res_idx_reg;
   logic res_last_reg;
   logic [WORD_W-1:0] mul_res_reg;
   logic [WORD_W-1:0] add_res_reg;
   logic [WORD_W-1:0] rcp_res_reg;
   wr_t wr_reg;
   logic done_reg;
   logic ready_reg;
   logic [WORD_W-1:0] opa;
   logic [WORD_W-1:0] opb;
   logic scalar_form;
   logic [VL_W-1:0] vl_use;

   assign issue_ready_out = ready_reg;
   assign done_out = done_reg;
   assign rd_en_out = rd_en_reg;
   assign rd_idx_out = rd_idx_reg;
   assign rd_first_vector_source_out = cmd_reg.src_j;
   assign rd_second_vector_source_out = cmd_reg.src_k;
   assign destination_vector_out = wr_reg;

   // lengths above the array size are clipped rather than running past the last element
   assign vl_use = (vector_length_register_in > VL_W'(ELEMS)) ? VL_W'(ELEMS) : vector_length_register_in;

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_reg <= ST_IDLE;
         cmd_reg <= '0;
         vl_reg <= '0;
         cnt_reg <= '0;
         rd_en_reg <= 1'b0;
         rd_idx_reg <= '0;
         rd_last_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               rd_en_reg <= 1'b0;
               rd_last_reg <= 1'b0;
               if (issue_valid_in && ready_reg && vl_use != '0)
               begin
                  cmd_reg <= issue_cmd_in;
                  vl_reg <= vl_use;
                  // a single element needs no run state
                  state_reg <= (vl_use == VL_W'(1)) ? ST_IDLE : ST_RUN;
                  cnt_reg <= VL_W'(1);
                  rd_en_reg <= 1'b1;
                  rd_idx_reg <= '0;
                  rd_last_reg <= (vl_use == VL_W'(1));
               end
            end
            ST_RUN:
            begin
               rd_en_reg <= 1'b1;
               rd_idx_reg <= cnt_reg[VL_W-2:0];
               cnt_reg <= cnt_reg + VL_W'(1);
               rd_last_reg <= (cnt_reg + VL_W'(1) == vl_reg);
               if (cnt_reg + VL_W'(1) == vl_reg)
                  state_reg <= ST_IDLE;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // register file answers here; select scalar or vector operands
   always_comb
   begin
      scalar_form = !cmd_reg.op[0] && cmd_reg.op != OP_RECIP;
      opa = first_vector_source_in;
      opb = second_vector_source_in;
      if (scalar_form)
         opa = cmd_reg.scalar;
      if (scalar_form && unit_of(cmd_reg.op) == UNIT_ADD && cmd_reg.src_j == '0)
         opa = '0;
   end

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         opv_reg <= 1'b0;
         op_idx_reg <= '0;
         op_last_reg <= 1'b0;
         res_unit_reg <= UNIT_NONE;
         res_idx_reg <= '0;
         res_last_reg <= 1'b0;
      end
      else
      begin
         opv_reg <= rd_en_reg;
         op_idx_reg <= rd_idx_reg;
         op_last_reg <= rd_last_reg;
         res_unit_reg <= opv_reg ? unit_of(cmd_reg.op) : UNIT_NONE;
         res_idx_reg <= op_idx_reg;
         res_last_reg <= opv_reg && op_last_reg;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
         mul_res_reg <= '0;
      else if (opv_reg && unit_of(cmd_reg.op) == UNIT_MUL)
      begin
         case (cmd_reg.op[2:1])
            2'h0: mul_res_reg <= fmul(opa, opb, MUL_PLAIN);
            2'h1: mul_res_reg <= fmul(opa, opb, MUL_HALF);
            2'h2: mul_res_reg <= fmul(opa, opb, MUL_ROUND);
            2'h3: mul_res_reg <= fadd(FP_TWO, fmul(opa, opb, MUL_ROUND), 1'b1);
            default: mul_res_reg <= '0;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
         add_res_reg <= '0;
      else if (opv_reg && unit_of(cmd_reg.op) == UNIT_ADD)
         add_res_reg <= fadd(opa, opb, cmd_reg.op[1]);
   end

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
         rcp_res_reg <= '0;
      else if (opv_reg && unit_of(cmd_reg.op) == UNIT_RCP)
         rcp_res_reg <= frcp(opb);
   end

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         wr_reg <= '0;
         done_reg <= 1'b0;
      end
      else
      begin
         wr_reg.en <= (res_unit_reg != UNIT_NONE);
         wr_reg.vreg <= cmd_reg.dst;
         wr_reg.idx <= res_idx_reg;
         case (res_unit_reg)
            UNIT_MUL: wr_reg.data <= mul_res_reg;
            UNIT_ADD: wr_reg.data <= add_res_reg;
            UNIT_RCP: wr_reg.data <= rcp_res_reg;
            default: wr_reg.data <= '0;
         endcase
         done_reg <= res_last_reg;
      end
   end

   // busy from acceptance until the last element has been handed to the writer
   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
         ready_reg <= 1'b1;
      else if (issue_valid_in && ready_reg && vl_use != '0)
         ready_reg <= 1'b0;
      else if (res_last_reg)
         ready_reg <= 1'b1;
   end

   // helper: writes of the current command
   logic [VL_W-1:0] wr_cnt_reg;
   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
         wr_cnt_reg <= '0;
      else if (issue_valid_in && ready_reg)
         wr_cnt_reg <= '0;
      else if (wr_reg.en)
         wr_cnt_reg <= wr_cnt_reg + VL_W'(1);
   end

   read_to_write_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      rd_en_reg |-> ##3 (wr_reg.en && wr_reg.idx == $past(rd_idx_reg, 3))) else $error("write late");
   ascending_index_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      wr_reg.en && $past(wr_reg.en) |-> wr_reg.idx == $past(wr_reg.idx) + 6'h1) else $error("index order");
   length_bound_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      wr_reg.en |-> wr_reg.idx < vl_reg) else $error("write beyond vector length");
   done_count_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      done_reg |-> wr_reg.en && wr_cnt_reg + VL_W'(1) == vl_reg && wr_reg.idx == vl_reg[VL_W-2:0] - 6'h1)
      else $error("done without exactly vector-length writes");
   half_low_zero_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      wr_reg.en && (cmd_reg.op == OP_HMUL_SV || cmd_reg.op == OP_HMUL_VV) |-> wr_reg.data[17:0] == 18'h0)
      else $error("half product low bits not zero");
   add_normal_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      wr_reg.en && unit_of(cmd_reg.op) == UNIT_ADD |-> wr_reg.data[47] || wr_reg.data == 64'h0)
      else $error("add result not normalized");
   dest_reg_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      wr_reg.en |-> wr_reg.vreg == cmd_reg.dst && (!ready_reg || $past(res_last_reg)))
      else $error("write to wrong destination");
   busy_no_issue_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      issue_valid_in && ready_reg && vl_use != '0 |=> !ready_reg && rd_en_reg && rd_idx_reg == '0)
      else $error("accepted command did not start reading");
endmodule

// ==== vreg_file_model.sv ====
`timescale 1ns/1ps
module vreg_file_model
#(
   parameter int ELEMS = vfp_pkg::MAX_ELEMS
)
(
   // clock
   input wire logic clock_in,
   // read port
   input wire logic rd_en_in,
   input wire logic [vfp_pkg::VREG_W-1:0] rd_j_in,
   input wire logic [vfp_pkg::VREG_W-1:0] rd_k_in,
   input wire logic [vfp_pkg::VL_W-2:0] rd_idx_in,
   output logic [vfp_pkg::WORD_W-1:0] j_data_out,
   output logic [vfp_pkg::WORD_W-1:0] k_data_out,
   // write port
   input wire vfp_pkg::wr_t wr_in
);
   import vfp_pkg::*;
   logic [WORD_W-1:0] mem [8][ELEMS];
   initial
   begin
      j_data_out = '0;
      k_data_out = '0;
   end
   // data is not held between reads: the inverse shows up so a late sample is caught
   always @(posedge clock_in)
   begin
      if (rd_en_in)
      begin
         j_data_out <= mem[rd_j_in][rd_idx_in];
         k_data_out <= mem[rd_k_in][rd_idx_in];
      end
      else
      begin
         j_data_out <= ~j_data_out;
         k_data_out <= ~k_data_out;
      end
      if (wr_in.en)
         mem[wr_in.vreg][wr_in.idx] <= wr_in.data;
   end
endmodule

// ==== vector_float_mul_add_recip_tb.sv ====
`timescale 1ns/1ps
module vector_float_mul_add_recip_tb;
   import vfp_pkg::*;
   localparam logic [63:0] F1 = 64'h4001_8000_0000_0000;
   localparam logic [63:0] F15 = 64'h4001_c000_0000_0000;
   localparam logic [63:0] F3 = 64'h4002_c000_0000_0000;
   localparam logic [63:0] F6 = 64'h4003_c000_0000_0000;
   localparam logic [63:0] F225 = 64'h4002_9000_0000_0000;
   localparam logic [63:0] FH = 64'h4000_8000_0000_0000;
   localparam logic [63:0] FODD = 64'h4001_8000_0000_0001;
   localparam logic [63:0] FU1 = 64'h4002_4000_0000_0000;
   localparam logic [63:0] FUM = 64'h4001_4000_0000_0000;
   localparam logic [63:0] FN15 = 64'hc001_c000_0000_0000;
   localparam logic [63:0] FNQ = 64'hbfff_8000_0000_0000;
   localparam logic [63:0] SENT = 64'h5a5a_5a5a_5a5a_5a5a;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic issue_valid = 1'b0;
   cmd_t issue_cmd = '0;
   logic [6:0] vl_in = '0;
   logic ready, done, rd_en;
   logic [2:0] rd_j, rd_k, cur_dst;
   logic [5:0] rd_idx;
   logic [63:0] j_data, k_data;
   wr_t wr;
   int mismatches = 0;
   int n_checks = 0;
   int wr_seen = 0;
   int cycles = 0;

   vector_float_mul_add_recip #(.ELEMS(64)) dut (
      .clock_in(clock_in), .nrst_in(nrst_in), .issue_valid_in(issue_valid), .issue_cmd_in(issue_cmd),
      .vector_length_register_in(vl_in), .issue_ready_out(ready), .done_out(done), .rd_en_out(rd_en),
      .rd_first_vector_source_out(rd_j), .rd_second_vector_source_out(rd_k), .rd_idx_out(rd_idx),
      .first_vector_source_in(j_data), .second_vector_source_in(k_data), .destination_vector_out(wr));
   vreg_file_model #(.ELEMS(64)) m (
      .clock_in(clock_in), .rd_en_in(rd_en), .rd_j_in(rd_j), .rd_k_in(rd_k), .rd_idx_in(rd_idx),
      .j_data_out(j_data), .k_data_out(k_data), .wr_in(wr));

   initial
   begin
      forever #12.5 clock_in = ~clock_in;
   end

   task automatic check_word(input logic [63:0] got, input logic [63:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic check_cnt(input logic [31:0] got, input int exp, input string msg);
      n_checks++;
      if (got !== 32'(exp))
      begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         $display("MISMATCH t=%0t run hung", $time);
         stop_test();
      end
   end

   // every write must land in the named register, in ascending element order
   always @(posedge clock_in)
   begin
      if (nrst_in === 1'b1 && wr.en === 1'b1)
      begin
         check_cnt(32'(wr.idx), wr_seen, "write index");
         check_word(64'(wr.vreg), 64'(cur_dst), "write register");
         wr_seen++;
      end
   end

   task automatic run_op(input logic [6:0] op, input logic [2:0] d, input logic [2:0] j, input logic [2:0] k,
                         input logic [63:0] s, input logic [6:0] vl);
      int n;
      n = 0;
      @(negedge clock_in);
      cur_dst = d;
      wr_seen = 0;
      issue_cmd = '{op: op, dst: d, src_j: j, src_k: k, scalar: s};
      vl_in = vl;
      issue_valid = 1'b1;
      @(negedge clock_in);
      issue_valid = 1'b0;
      while (done !== 1'b1 && n < 300)
      begin
         @(negedge clock_in);
         n++;
      end
      check_word(64'(done), 64'h1, "done pulse");
      @(negedge clock_in);
      check_cnt(wr_seen, int'(vl), "write count");
      check_word(64'(ready), 64'h1, "ready after done");
   endtask

   task automatic t_mul_basic;
      m.mem[1][0] = F1;
      m.mem[1][1] = F15;
      m.mem[1][2] = F3;
      m.mem[2][3] = SENT;
      m.mem[3][2] = SENT;
      run_op(OP_MUL_SV, 3'h2, 3'h0, 3'h1, FP_TWO, 7'h03);
      check_word(m.mem[2][0], FP_TWO, "sv prod 0");
      check_word(m.mem[2][1], F3, "sv prod 1");
      check_word(m.mem[2][2], F6, "sv prod 2");
      check_word(m.mem[2][3], SENT, "beyond length");
      run_op(OP_MUL_VV, 3'h3, 3'h1, 3'h1, F6, 7'h02);
      check_word(m.mem[3][0], F1, "vv prod 0");
      check_word(m.mem[3][1], F225, "vv prod 1");
      check_word(m.mem[3][2], SENT, "beyond length");
      m.mem[4][0] = FUM;
      run_op(OP_MUL_SV, 3'h6, 3'h4, 3'h1, FUM, 7'h01);
      check_word(64'(m.mem[6][0][47]), 64'h0, "unnormalized prod");
      $display("test mul_basic done");
   endtask

   task automatic t_mul_modes;
      logic [6:0] ops[6] = '{OP_HMUL_SV, OP_HMUL_VV, OP_RMUL_SV, OP_RMUL_VV, OP_IMUL_SV, OP_IMUL_VV};
      logic [63:0] a[6] = '{FODD, FODD, FODD, F15, F15, F15};
      logic [63:0] b[6] = '{F1, F1, F1, F15, F1, F15};
      logic [63:0] e[6] = '{F1, F1, FODD, F225, FH, FNQ};
      for (int i = 0; i < 6; i++)
      begin
         m.mem[4][0] = a[i];
         m.mem[5][0] = b[i];
         run_op(ops[i], 3'h6, 3'h4, 3'h5, a[i], 7'h01);
         check_word(m.mem[6][0], e[i], "mul mode");
      end
      $display("test mul_modes done");
   endtask

   task automatic t_add_modes;
      logic [6:0] ops[8] = '{OP_ADD_SV, OP_ADD_VV, OP_SUB_SV, OP_SUB_VV, OP_SUB_VV, OP_ADD_SV, OP_SUB_SV, OP_ADD_VV};
      logic [2:0] js[8] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h0, 3'h4};
      logic [63:0] s[8] = '{F1, F6, F3, F6, F6, F3, F3, F6};
      logic [63:0] va[8] = '{F6, F15, F6, F3, F1, F6, F6, FU1};
      logic [63:0] vb[8] = '{F1, F15, F1, F15, F1, FU1, F15, FU1};
      logic [63:0] e[8] = '{FP_TWO, F3, FP_TWO, F15, 64'h0, F1, FN15, FP_TWO};
      for (int i = 0; i < 8; i++)
      begin
         m.mem[4][0] = va[i];
         m.mem[5][0] = vb[i];
         run_op(ops[i], 3'h6, js[i], 3'h5, s[i], 7'h01);
         check_word(m.mem[6][0], e[i], "add mode");
      end
      $display("test add_modes done");
   endtask

   task automatic t_recip;
      m.mem[4][0] = F15;
      m.mem[4][1] = F15;
      m.mem[7][2] = SENT;
      run_op(OP_RECIP, 3'h7, 3'h4, 3'h4, F6, 7'h02);
      for (int i = 0; i < 2; i++)
         check_word(64'(m.mem[7][i][63:47]), 64'h8001, "recip range");
      check_word(m.mem[7][2], SENT, "beyond length");
      $display("test recip done");
   endtask

   task automatic t_full_and_zero;
      for (int i = 0; i < 64; i++)
         m.mem[1][i] = F15;
      run_op(OP_MUL_SV, 3'h0, 3'h0, 3'h1, F1, 7'h40);
      for (int i = 0; i < 64; i++)
         check_word(m.mem[0][i], F15, "full length");
      m.mem[2][0] = SENT;
      @(negedge clock_in);
      cur_dst = 3'h2;
      wr_seen = 0;
      issue_cmd = '{op: OP_MUL_SV, dst: 3'h2, src_j: 3'h0, src_k: 3'h1, scalar: F1};
      vl_in = 7'h00;
      issue_valid = 1'b1;
      @(negedge clock_in);
      issue_valid = 1'b0;
      repeat (10) @(negedge clock_in);
      check_cnt(wr_seen, 0, "zero length writes");
      check_word(64'(ready), 64'h1, "zero length ready");
      check_word(m.mem[2][0], SENT, "zero length dest");
      $display("test full_and_zero done");
   endtask

   initial
   begin
      repeat (8) @(negedge clock_in);
      check_word({61'h0, ready, done, wr.en}, 64'h4, "reset outputs");
      nrst_in = 1'b1;
      @(negedge clock_in);
      t_mul_basic();
      t_mul_modes();
      t_add_modes();
      t_recip();
      t_full_and_zero();
      stop_test();
   end
endmodule
